// [hw/timer2_pkg.sv]
/*
 Shared constants for the timer clock-out block: register indices, field
 positions, reset values, mode codes and clock-source codes.
 Assumes a 32-bit AHB-Lite register bus with one register per word.
*/
`default_nettype none
package timer2_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'hC8;
   localparam logic [7:0] IDX_MODE = 8'hC9;
   localparam logic [7:0] IDX_RLD_L = 8'hCA;
   localparam logic [7:0] IDX_RLD_H = 8'hCB;
   localparam logic [7:0] IDX_CNT_L = 8'hCC;
   localparam logic [7:0] IDX_CNT_H = 8'hCD;
   localparam logic [7:0] IDX_MODE1 = 8'h93;
   // Control register fields
   localparam int CTRL_MAIN_FLAG = 7;
   localparam int CTRL_EXT_FLAG = 6;
   localparam int CTRL_BIT5 = 5;
   localparam int CTRL_BIT4 = 4;
   localparam int CTRL_FALL_EN = 3;
   localparam int CTRL_MAIN_RUN = 2;
   localparam int CTRL_SRC0 = 1;
   localparam int CTRL_CAPREL = 0;
   // Mode register fields
   localparam int MODE_SPLIT = 7;
   localparam int MODE_LSRC0 = 6;
   localparam int MODE_RISE_EN = 5;
   localparam int MODE_SRC1 = 4;
   localparam int MODE_LOW_RUN = 3;
   localparam int MODE_CLK_OE = 1;
   localparam int MODE_BIT0 = 0;
   // Mode register 1 fields
   localparam int MODE1_LSRC1 = 7;
   localparam int MODE1_IGNORE = 6;
   localparam int MODE1_VIEW = 5;
   localparam int MODE1_SRC2 = 4;
   localparam int MODE1_BIT1 = 3;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] MODE1_RESET = 8'h00;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   // Counter limits and prescaler terminal count (divide by 12)
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [7:0] HALF_MAX = 8'hFF;
   localparam logic [3:0] PRESCALE_TC = 4'hB;
   // Mode codes {split, bit1, capture/reload, bit0}
   typedef enum logic [3:0] {
      MODE_FULL0 = 4'h0,
      MODE_SPLIT0 = 4'h8,
      MODE_PWM8 = 4'hC
   } timer_mode_type;
   // Main clock source codes {bit2, bit1, bit0}
   typedef enum logic [2:0] {
      SRC_DIV12 = 3'h0,
      SRC_PIN = 3'h1,
      SRC_SYS = 3'h2,
      SRC_IRQ0 = 3'h3,
      SRC_NONE = 3'h4,
      SRC_T0OVF = 3'h5,
      SRC_CMP = 3'h6,
      SRC_KBD = 3'h7
   } src_sel_type;
   // Low-half clock source codes {bit1, bit0}
   typedef enum logic [1:0] {
      LSRC_DIV12 = 2'h0,
      LSRC_SYS = 2'h1,
      LSRC_SER = 2'h2,
      LSRC_IRQ0 = 2'h3
   } low_src_type;
endpackage
`default_nettype wire

// [hw/input_edge_sync.sv]
/*
 Two-flop synchroniser with edge detection for asynchronous pins.
 Assumes each input edge lasts longer than two clock periods.
*/
`timescale 1ns/1ps
`default_nettype none
module input_edge_sync #(
   parameter int WIDTH = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] meta_q; // First stage, read only by second
   logic [WIDTH-1:0] sync_q; // Second stage, safe to use
   logic [WIDTH-1:0] prev_q; // Delayed copy for edges

   // Synchroniser chain
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge pulses, one cycle each
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
endmodule // input_edge_sync
`default_nettype wire

// [hw/tick_prescaler.sv]
/*
 Free-running prescaler giving a one-cycle tick every TC+1 clocks.
 Assumes one clock domain; no enable, so phase is fixed from reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler
   import timer2_pkg::*;
#(
   parameter logic [3:0] TC = PRESCALE_TC
) (
   input wire logic hclk,
   input wire logic hresetn,
   output logic tick
);
   logic [3:0] div_q; // Cycle counter

   // Wraps at the terminal count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 4'h0;
      end else if (div_q == TC) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   assign tick = (div_q == TC);
endmodule // tick_prescaler
`default_nettype wire

// [hw/timer2_clock_out_control.sv]
/*
 Timer with auto-reload, split halves, programmable clock output and
 serial baud ticks, with its registers behind an AHB-Lite slave.
 Assumes event inputs are one-cycle pulses on hclk; the count pin and
 external trigger are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module timer2_clock_out_control
   import timer2_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic count_pin,
   input wire logic external_trigger_input,
   input wire logic ext_irq0_event,
   input wire logic timer0_overflow_event,
   input wire logic comparator_event,
   input wire logic keyboard_event,
   input wire logic serial_timer_overflow,
   input wire logic timer1_overflow_event,
   output logic clock_out_pin,
   output logic timer_irq,
   output logic rx_baud_tick,
   output logic tx_baud_tick
);
   // Bus state
   logic [7:0] addr_q; // Word index of the data phase
   logic wr_q; // Write data phase pending
   logic rd_q; // Read waiting for its data cycle
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;
   // Registers
   logic [7:0] ctrl_q; // Bits 5 and 4 hold the baud sources
   logic [7:0] mode_q;
   logic [7:0] mode1_q; // Low three bits unused, read zero
   logic low_flag_q;
   logic low_en_q;
   logic [15:0] reload_q;
   logic [15:0] count_q;
   logic [15:0] cnt_d;
   // Outputs
   logic clk_out_q;
   logic irq_q;
   logic rx_tick_q;
   logic tx_tick_q;
   // Decoded fields
   logic split, main_run, low_run, caprel, baud, view, ignore;
   logic [3:0] mode_code;
   logic [2:0] src_sel;
   logic [1:0] low_sel;
   // Ticks and events
   logic div12_tick;
   logic [1:0] pin_rise, pin_fall;
   logic main_tick, low_tick, high_tick;
   logic full_ovf, low_ovf, high_ovf, t2_ovf;
   logic ext_event, ext_reload, capture;
   logic clk_out_mode;
   // Byte writes decoded in the data phase
   logic [7:0] wbyte;
   logic wr_ctrl, wr_mode, wr_mode1, wr_rl, wr_rh, wr_cl, wr_ch;

   // Async pins: bit 0 count pin, bit 1 external trigger
   input_edge_sync #(
      .WIDTH(2)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in({external_trigger_input, count_pin}),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // System clock divided by 12
   tick_prescaler #(
      .TC(PRESCALE_TC)
   ) u_div12 (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(div12_tick)
   );

   // Field decode
   assign split = mode_q[MODE_SPLIT];
   assign main_run = ctrl_q[CTRL_MAIN_RUN];
   assign low_run = mode_q[MODE_LOW_RUN];
   assign caprel = ctrl_q[CTRL_CAPREL];
   assign baud = ctrl_q[CTRL_BIT5] | ctrl_q[CTRL_BIT4];
   assign view = mode1_q[MODE1_VIEW];
   assign ignore = mode1_q[MODE1_IGNORE];
   assign mode_code = {split, mode1_q[MODE1_BIT1], caprel, mode_q[MODE_BIT0]};
   assign src_sel = {mode1_q[MODE1_SRC2], mode_q[MODE_SRC1], ctrl_q[CTRL_SRC0]};
   assign low_sel = {mode1_q[MODE1_LSRC1], mode_q[MODE_LSRC0]};
   // Clock-out only in mode 0, full or split
   assign clk_out_mode = mode_q[MODE_CLK_OE] &
      ((mode_code == MODE_FULL0) | (mode_code == MODE_SPLIT0));

   // Main clock; code 3 feeds the high half from low overflows in split
   always_comb begin
      unique case (src_sel_type'(src_sel))
         SRC_DIV12: main_tick = div12_tick;
         SRC_PIN: main_tick = pin_fall[0];
         SRC_SYS: main_tick = 1'b1;
         SRC_IRQ0: main_tick = ext_irq0_event;
         SRC_NONE: main_tick = 1'b0;
         SRC_T0OVF: main_tick = timer0_overflow_event;
         SRC_CMP: main_tick = comparator_event;
         SRC_KBD: main_tick = keyboard_event;
      endcase
   end
   assign high_tick = (src_sel == SRC_IRQ0) ? low_ovf : main_tick;

   // Low-half clock
   always_comb begin
      unique case (low_src_type'(low_sel))
         LSRC_DIV12: low_tick = div12_tick;
         LSRC_SYS: low_tick = 1'b1;
         LSRC_SER: low_tick = serial_timer_overflow;
         LSRC_IRQ0: low_tick = ext_irq0_event;
      endcase
   end

   // Overflow events
   assign full_ovf = !split && main_run && main_tick && (count_q == COUNT_MAX);
   assign low_ovf = split && low_run && low_tick && (count_q[7:0] == HALF_MAX);
   assign high_ovf = split && main_run && high_tick && (count_q[15:8] == HALF_MAX);
   // One overflow rate serves clock out and baud
   assign t2_ovf = split ? low_ovf : full_ovf;

   // External trigger: either edge as enabled
   assign ext_event = (pin_fall[1] & ctrl_q[CTRL_FALL_EN]) |
      (pin_rise[1] & mode_q[MODE_RISE_EN]);
   // Baud use blocks reload and capture
   assign ext_reload = ext_event && !baud && !caprel && !split;
   assign capture = ext_event && !baud && caprel && !split;

   // Data-phase write decode; only the low byte lane carries data
   assign wbyte = hwdata[7:0];
   assign wr_ctrl = wr_q && (addr_q == IDX_CTRL);
   assign wr_mode = wr_q && (addr_q == IDX_MODE);
   assign wr_mode1 = wr_q && (addr_q == IDX_MODE1);
   assign wr_rl = wr_q && (addr_q == IDX_RLD_L);
   assign wr_rh = wr_q && (addr_q == IDX_RLD_H);
   assign wr_cl = wr_q && (addr_q == IDX_CNT_L);
   assign wr_ch = wr_q && (addr_q == IDX_CNT_H);

   // Bus slave; writes are zero-wait, reads take one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         hrdata_q <= 32'h00000000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         wr_q <= 1'b0;
         if (rd_q) begin
            // Data cycle sees any write that landed before it
            rd_q <= 1'b0;
            hreadyout_q <= 1'b1;
            hrdata_q <= {24'h000000, read_byte(addr_q)};
         end else if (hsel && htrans[1] && hready) begin
            addr_q <= haddr[9:2];
            wr_q <= hwrite;
            rd_q <= !hwrite;
            hreadyout_q <= hwrite;
         end
      end
   end

   // Read mux; unmapped words read zero
   function automatic logic [7:0] read_byte(input logic [7:0] idx);
      logic [7:0] b;
      b = 8'h00;
      unique case (idx)
         IDX_CTRL: begin
            b = ctrl_q;
            if (view) begin
               b[CTRL_BIT5] = low_flag_q;
               b[CTRL_BIT4] = low_en_q;
            end
         end
         IDX_MODE: b = mode_q;
         IDX_MODE1: b = mode1_q;
         IDX_RLD_L: b = reload_q[7:0];
         IDX_RLD_H: b = reload_q[15:8];
         IDX_CNT_L: b = count_q[7:0];
         IDX_CNT_H: b = count_q[15:8];
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // Control register; hardware set beats a software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= CTRL_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_q[CTRL_FALL_EN:0] <= wbyte[CTRL_FALL_EN:0];
            ctrl_q[CTRL_MAIN_FLAG] <= wbyte[CTRL_MAIN_FLAG];
            ctrl_q[CTRL_EXT_FLAG] <= wbyte[CTRL_EXT_FLAG];
            if (!view) begin
               ctrl_q[CTRL_BIT5] <= wbyte[CTRL_BIT5];
               ctrl_q[CTRL_BIT4] <= wbyte[CTRL_BIT4];
            end
         end
         // Baud mode never raises the overflow flag
         if ((full_ovf || high_ovf) && !baud) begin
            ctrl_q[CTRL_MAIN_FLAG] <= 1'b1;
         end
         if (ext_event) begin
            ctrl_q[CTRL_EXT_FLAG] <= 1'b1;
         end
      end
   end

   // Low-half flag and enable, reached through the view select
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_flag_q <= 1'b0;
         low_en_q <= 1'b0;
      end else begin
         if (wr_ctrl && view) begin
            low_flag_q <= wbyte[CTRL_BIT5];
            low_en_q <= wbyte[CTRL_BIT4];
         end
         if (low_ovf) begin
            low_flag_q <= 1'b1;
         end
      end
   end

   // Mode registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= MODE_RESET;
         mode1_q <= MODE1_RESET;
      end else begin
         if (wr_mode) begin
            mode_q <= wbyte;
         end
         if (wr_mode1) begin
            mode1_q <= {wbyte[7:3], 3'h0};
         end
      end
   end

   // Reload pair; capture modes store the count on a trigger edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reload_q <= CNT_RESET;
      end else begin
         if (capture) begin
            reload_q <= count_q;
         end
         if (wr_rl) begin
            reload_q[7:0] <= wbyte;
         end
         if (wr_rh) begin
            reload_q[15:8] <= wbyte;
         end
      end
   end

   // Counter next value; software writes take priority
   always_comb begin
      cnt_d = count_q;
      if (split) begin
         if (low_run && low_tick) begin
            cnt_d[7:0] = low_ovf ? reload_q[7:0] : count_q[7:0] + 8'h01;
         end
         if (main_run && high_tick) begin
            cnt_d[15:8] = high_ovf ? reload_q[15:8] : count_q[15:8] + 8'h01;
         end
      end else if (main_run && main_tick) begin
         // Capture modes wrap to zero instead of reloading
         if (full_ovf) begin
            cnt_d = caprel ? CNT_RESET : reload_q;
         end else begin
            cnt_d = count_q + 16'h0001;
         end
      end
      if (ext_reload) begin
         cnt_d = reload_q;
      end
      if (wr_cl) begin
         cnt_d[7:0] = wbyte;
      end
      if (wr_ch) begin
         cnt_d[15:8] = wbyte;
      end
   end

   // Counter state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q <= CNT_RESET;
      end else begin
         count_q <= cnt_d;
      end
   end

   // Clock out: half period per overflow gives 50% duty
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_out_q <= 1'b0;
      end else if (!clk_out_mode) begin
         clk_out_q <= 1'b0;
      end else if (t2_ovf) begin
         clk_out_q <= !clk_out_q;
      end
   end

   // Shared interrupt; baud mode and the ignore bit mask the overflow flag from the request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (ctrl_q[CTRL_MAIN_FLAG] && !ignore && !baud) ||
            ctrl_q[CTRL_EXT_FLAG] || (low_flag_q && low_en_q);
      end
   end

   // Serial baud ticks from this timer or from the other one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_tick_q <= 1'b0;
         tx_tick_q <= 1'b0;
      end else begin
         rx_tick_q <= ctrl_q[CTRL_BIT5] ? t2_ovf : timer1_overflow_event;
         tx_tick_q <= ctrl_q[CTRL_BIT4] ? t2_ovf : timer1_overflow_event;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign clock_out_pin = clk_out_q;
   assign timer_irq = irq_q;
   assign rx_baud_tick = rx_tick_q;
   assign tx_baud_tick = tx_tick_q;

   // Full overflow reloads the count on the next cycle unless capturing, trigger-reloaded or written
   property p_full_reload;
      @(posedge hclk) disable iff (!hresetn)
      (full_ovf && !caprel && !ext_reload && !wr_cl && !wr_ch) |=> (count_q == $past(reload_q));
   endproperty
   a_full_reload: assert property (p_full_reload) else $error("no reload on overflow");

   property p_low_reload;
      @(posedge hclk) disable iff (!hresetn)
      (low_ovf && !wr_cl) |=> (count_q[7:0] == $past(reload_q[7:0]));
   endproperty
   a_low_reload: assert property (p_low_reload) else $error("low half not reloaded");

   property p_flag_set;
      @(posedge hclk) disable iff (!hresetn)
      ((full_ovf || high_ovf) && !baud) |=> ctrl_q[CTRL_MAIN_FLAG];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("overflow flag missed");

   property p_no_flag_baud;
      @(posedge hclk) disable iff (!hresetn)
      (baud && !wr_ctrl && !ctrl_q[CTRL_MAIN_FLAG]) |=> !ctrl_q[CTRL_MAIN_FLAG];
   endproperty
   a_no_flag_baud: assert property (p_no_flag_baud) else $error("flag set in baud mode");

   property p_clk_toggle;
      @(posedge hclk) disable iff (!hresetn)
      (clk_out_mode && t2_ovf) ##1 clk_out_mode |-> (clk_out_q != $past(clk_out_q));
   endproperty
   a_clk_toggle: assert property (p_clk_toggle) else $error("clock out did not toggle");

   property p_ext_flag;
      @(posedge hclk) disable iff (!hresetn)
      ext_event |=> ctrl_q[CTRL_EXT_FLAG] ##1 timer_irq;
   endproperty
   a_ext_flag: assert property (p_ext_flag) else $error("trigger edge not flagged");

   property p_low_irq;
      @(posedge hclk) disable iff (!hresetn)
      (low_ovf && low_en_q && !wr_ctrl) |=> low_flag_q ##1 timer_irq;
   endproperty
   a_low_irq: assert property (p_low_irq) else $error("low half interrupt missed");

   property p_baud_tick;
      @(posedge hclk) disable iff (!hresetn)
      (ctrl_q[CTRL_BIT4] && t2_ovf) |=> tx_baud_tick;
   endproperty
   a_baud_tick: assert property (p_baud_tick) else $error("baud tick missing");

   property p_high_hold;
      @(posedge hclk) disable iff (!hresetn)
      (split && !main_run && !wr_ch) |=> $stable(count_q[15:8]);
   endproperty
   a_high_hold: assert property (p_high_hold) else $error("high half ran while stopped");

   property p_no_reload_baud;
      @(posedge hclk) disable iff (!hresetn)
      (baud && ext_event && !split && !(main_run && main_tick) && !wr_cl && !wr_ch)
         |=> $stable(count_q);
   endproperty
   a_no_reload_baud: assert property (p_no_reload_baud) else $error("reload in baud mode");
endmodule // timer2_clock_out_control
`default_nettype wire

// [tb/clock_out_monitor.sv]
/*
 Partner model: a consumer of the generated clock that measures the
 length of its high and low phases in hclk cycles.
 Assumes the clock output is registered on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_out_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clock_out_pin,
   output logic [15:0] hp_hi,
   output logic [15:0] hp_lo
);
   logic prev_q; // Last sampled level
   logic [15:0] run_q; // Cycles since last toggle
   // Phase timer; each phase is kept apart so duty errors show
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q <= 1'b0;
         run_q <= 16'h0000;
         hp_hi <= 16'h0000;
         hp_lo <= 16'h0000;
      end else begin
         prev_q <= clock_out_pin;
         if (clock_out_pin !== prev_q) begin
            // A phase just ended; store its length
            run_q <= 16'h0000;
            if (prev_q) hp_hi <= run_q + 16'h0001;
            else hp_lo <= run_q + 16'h0001;
         end else begin
            run_q <= run_q + 16'h0001;
         end
      end
   end
endmodule // clock_out_monitor
`default_nettype wire

// [tb/tb_top.sv]
/*
 Self-checking bench: register access over AHB-Lite, clock-out phases,
 flags, interrupt and baud ticks. Assumes hclk at 10 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import timer2_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, count_pin, trig, hreadyout, hresp;
   logic clock_out_pin, timer_irq, rx_baud_tick, tx_baud_tick;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [5:0] ev; // Event pulse inputs, kept quiet
   logic [7:0] rd; // Last read byte
   logic [15:0] hp_hi, hp_lo;
   int err_count = 0;
   int total_checks = 0;
   int tx_n = 0; // Transmit ticks seen
   int rx_n = 0; // Receive ticks seen
   int n0, n1;
   timer2_clock_out_control DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .count_pin(count_pin),
      .external_trigger_input(trig), .ext_irq0_event(ev[0]),
      .timer0_overflow_event(ev[1]), .comparator_event(ev[2]),
      .keyboard_event(ev[3]), .serial_timer_overflow(ev[4]),
      .timer1_overflow_event(ev[5]), .clock_out_pin(clock_out_pin),
      .timer_irq(timer_irq), .rx_baud_tick(rx_baud_tick),
      .tx_baud_tick(tx_baud_tick));
   clock_out_monitor mon (.hclk(hclk), .hresetn(hresetn),
      .clock_out_pin(clock_out_pin), .hp_hi(hp_hi), .hp_lo(hp_lo));
   // Clock, 100 ns period
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // Tick counters; nonblocking so samples after an edge are stable
   always @(posedge hclk) begin
      if (tx_baud_tick === 1'b1) tx_n <= tx_n + 1;
      if (rx_baud_tick === 1'b1) rx_n <= rx_n + 1;
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One single transfer; called just after a rising edge
   task automatic rg(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      hsel <= 1'b1;
      haddr <= {22'h000000, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      // Data phase; wait states come from the slave
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
   endtask
   // Verdict and end of run
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      finish_test();
   end
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      count_pin = 1'b0;
      trig = 1'b0;
      ev = 6'h00;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values and a hole in the map
      rg(1'b0, IDX_CTRL, 8'h00);
      chk(rd, CTRL_RESET);
      rg(1'b0, IDX_MODE, 8'h00);
      chk(rd, MODE_RESET);
      rg(1'b0, 8'h00, 8'h00);
      chk(rd, 8'h00);
      // Full mode start: source, reload, count, enable, run
      rg(1'b1, IDX_MODE, 8'h10);
      rg(1'b1, IDX_RLD_L, 8'hFC);
      rg(1'b1, IDX_RLD_H, 8'hFF);
      rg(1'b1, IDX_CNT_L, 8'hFC);
      rg(1'b1, IDX_CNT_H, 8'hFF);
      rg(1'b1, IDX_MODE, 8'h12);
      rg(1'b1, IDX_CTRL, 8'h04);
      repeat (30) @(posedge hclk);
      chk(hp_hi, 16'h0004);
      chk(hp_lo, 16'h0004);
      chk(timer_irq, 1'b1);
      rg(1'b0, IDX_CTRL, 8'h00);
      chk(rd[7], 1'b1);
      // Ignore bit masks the request, not the flag
      rg(1'b1, IDX_MODE1, 8'h40);
      rg(1'b1, IDX_CTRL, 8'h04);
      repeat (10) @(posedge hclk);
      chk(timer_irq, 1'b0);
      rg(1'b0, IDX_CTRL, 8'h00);
      chk(rd[7], 1'b1);
      // Transmit baud from this timer; second write clears a racing flag
      rg(1'b1, IDX_CTRL, 8'h1C);
      rg(1'b1, IDX_CTRL, 8'h1C);
      n0 = tx_n;
      n1 = rx_n;
      repeat (40) @(posedge hclk);
      chk(tx_n - n0, 10);
      chk(rx_n - n1, 0);
      chk(hp_hi, 16'h0004);
      rg(1'b0, IDX_CTRL, 8'h00);
      chk(rd[7], 1'b0);
      // Falling trigger edge while clocking the serial port, counter parked
      rg(1'b1, IDX_CTRL, 8'h18);
      rg(1'b1, IDX_CNT_L, 8'h00);
      // Trigger held six cycles, well below half the system clock
      trig <= 1'b1;
      repeat (6) @(posedge hclk);
      trig <= 1'b0;
      repeat (6) @(posedge hclk);
      rg(1'b0, IDX_CTRL, 8'h00);
      chk(rd[6], 1'b1);
      chk(timer_irq, 1'b1);
      // Reload low byte is FC; a wrongful reload would show here
      rg(1'b0, IDX_CNT_L, 8'h00);
      chk(rd, 8'h00);
      chk(hresp, 1'b0);
      // Split mode, low half from system/12 then system clock
      rg(1'b1, IDX_CTRL, 8'h00);
      rg(1'b1, IDX_MODE1, 8'h20);
      for (int s = 0; s < 2; s++) begin
         rg(1'b1, IDX_MODE, {1'b1, s[0], 6'h00});
         rg(1'b1, IDX_RLD_L, 8'hFE);
         rg(1'b1, IDX_CNT_L, 8'hFE);
         rg(1'b1, IDX_MODE, {1'b1, s[0], 6'h02});
         rg(1'b1, IDX_MODE, {1'b1, s[0], 6'h0A});
         repeat (130) @(posedge hclk);
         chk(hp_hi, (s == 1) ? 16'h0002 : 16'h0018);
         chk(hp_lo, (s == 1) ? 16'h0002 : 16'h0018);
      end
      rg(1'b0, IDX_CTRL, 8'h00);
      chk(rd[5], 1'b1);
      chk(rd[7], 1'b0);
      chk(timer_irq, 1'b0);
      // With view set, bit 4 is the interrupt enable, not a baud source
      n0 = tx_n;
      rg(1'b1, IDX_CTRL, 8'h10);
      repeat (8) @(posedge hclk);
      chk(timer_irq, 1'b1);
      chk(tx_n - n0, 0);
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
